// ==== design/sbc_mcu_ctrl.sv ====
// Purpose: MCU-facing control of a system basis chip: serial slave, reset pin,
//          interrupt, watchdog strap, PWM gating, wake inputs and mux select
// Assumes: All pins are asynchronous to clk and pass two flip-flops
// Notes:   Long counts are parameters so a bench can shorten them
`timescale 1ns/1ps
`default_nettype none
module sbc_mcu_ctrl
	import sbc_pkg::*;
#(
	parameter int unsigned RST_CYC  = RST_PULSE_CYC,
	parameter int unsigned NREQ_CYC = NREQ_TMO_CYC,
	parameter int unsigned WDD_CYC  = WD_DEF_CYC,
	parameter int unsigned WDW_CYC  = WD_WIN_CYC,
	parameter int unsigned CSP_CYC  = CS_PERIOD_CYC
) (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       sclk,
	input  wire logic       cs_n,
	input  wire logic       mosi,
	output logic            miso_o,
	output logic            miso_oe,
	input  wire logic       rst_pin_n_i,
	output logic            rst_pin_n_o,
	output logic            rst_pin_n_oe,
	output logic            irq_n,
	input  wire logic [1:0] watchdog_strap_pin,
	input  wire logic       pwm_drive_input,
	input  wire logic       wake_input_a,
	input  wire logic       wake_input_b,
	input  wire logic [3:0] fault_i,
	output logic            high_side_switch,
	output logic            low_side_switch_a,
	output logic            low_side_switch_b,
	output logic [1:0]      analog_mux_output,
	output logic            divider_hi_ratio,
	output logic            divider_conn_a,
	output logic            divider_conn_b,
	output logic            regulator_on,
	output logic            regulator_limited,
	output logic            lin_enable,
	output logic            lin_slew_fast,
	output logic [4:0]      mode_state
);
	////////////////////////////////////////////////////////////////////////
	// Input synchronisers
	logic [12:0] s1_q;                // First stage, read only by s2
	logic [12:0] s2_q;                // Safe synchronised copy
	logic        sclk_s3_q;           // Edge history of serial clock
	logic        cs_s3_q;             // Edge history of chip select
	// Stages run through reset, so the strap is valid when it is caught
	always_ff @(posedge clk) begin
		s1_q <= {sclk, cs_n, mosi, rst_pin_n_i, pwm_drive_input, wake_input_a,
			wake_input_b, fault_i, watchdog_strap_pin};
		s2_q <= s1_q;
		if (rst) begin
			// Idle levels, so no false edge follows reset
			sclk_s3_q <= 1'b0;
			cs_s3_q   <= 1'b1;
		end else begin
			sclk_s3_q <= s2_q[12];
			cs_s3_q   <= s2_q[11];
		end
	end
	logic       sclk_s, cs_s, mosi_s, rstp_s, pwm_s, wa_s, wb_s;
	logic [3:0] flt_s;
	logic [1:0] strap_s;
	assign {sclk_s, cs_s, mosi_s, rstp_s, pwm_s, wa_s, wb_s, flt_s, strap_s} = s2_q;
	logic sclk_rise, sclk_fall, cs_fall, cs_rise;
	assign sclk_rise = sclk_s & ~sclk_s3_q;
	assign sclk_fall = ~sclk_s & sclk_s3_q;
	assign cs_fall   = ~cs_s & cs_s3_q;
	assign cs_rise   = cs_s & ~cs_s3_q;

	////////////////////////////////////////////////////////////////////////
	// Serial slave
	logic [7:0] rx_q, rx_d;           // Incoming shift register
	logic [7:0] tx_q, tx_d;           // Outgoing shift register
	logic [3:0] bit_q, bit_d;         // Bits taken this frame
	logic       frm_q, frm_d;         // Frame accepted pulse
	sbc_frame_t frame_q, frame_d;     // Latched frame
	sbc_evt_t   snap_q, snap_d;       // Flags reported this frame
	sbc_evt_t   evt_q, evt_d;         // Sticky event flags
	sbc_mode_t  mode_q, mode_d;       // Operating state
	logic       rd_a, rd_b;           // Digital wake states for reading
	always_comb begin
		rx_d    = rx_q;
		tx_d    = tx_q;
		bit_d   = bit_q;
		frm_d   = 1'b0;
		frame_d = frame_q;
		snap_d  = snap_q;
		if (cs_fall) begin
			// Load status byte at frame start
			bit_d  = 4'h0;
			snap_d = evt_q;
			tx_d   = {evt_q, rd_a, rd_b, 1'b0};
		end else if (!cs_s) begin
			if (sclk_rise) begin
				// Sample input on rising clock
				rx_d = {rx_q[6:0], mosi_s};
				if (bit_q != 4'hf)
					bit_d = bit_q + 4'h1;
			end
			if (sclk_fall)
				tx_d = {tx_q[6:0], 1'b0};
		end
		if (cs_rise && bit_q == FRAME_BITS) begin
			// Latch only complete frames
			frm_d   = 1'b1;
			frame_d = rx_q;
		end // Other counts dropped
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			rx_q    <= 8'h00;
			tx_q    <= 8'h00;
			bit_q   <= 4'h0;
			frm_q   <= 1'b0;
			frame_q <= '0;
			snap_q  <= '0;
		end else begin
			rx_q    <= rx_d;
			tx_q    <= tx_d;
			bit_q   <= bit_d;
			frm_q   <= frm_d;
			frame_q <= frame_d;
			snap_q  <= snap_d;
		end
	end
	assign miso_o  = tx_q[7];
	assign miso_oe = ~cs_s;

	////////////////////////////////////////////////////////////////////////
	// Reset pin filter and strap capture
	logic [7:0] flt_cnt_q, flt_cnt_d; // Stability counter
	logic       rstf_q, rstf_d;       // Filtered pin level
	logic [1:0] strap_q, strap_d;     // Strap caught after reset
	logic       strap_ok_q, strap_ok_d;
	always_comb begin
		rstf_d     = rstf_q;
		flt_cnt_d  = 8'h00;
		strap_d    = strap_q;
		strap_ok_d = 1'b1;
		if (!strap_ok_q)
			strap_d = strap_s;
		if (rstp_s != rstf_q) begin
			// Level must hold before it is believed
			flt_cnt_d = flt_cnt_q + 8'h01;
			if (flt_cnt_d >= RST_FILT_CYC) begin
				rstf_d    = rstp_s;
				flt_cnt_d = 8'h00;
			end
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			flt_cnt_q  <= 8'h00;
			rstf_q     <= 1'b1;
			strap_q    <= STRAP_GND;
			strap_ok_q <= 1'b0;
		end else begin
			flt_cnt_q  <= flt_cnt_d;
			rstf_q     <= rstf_d;
			strap_q    <= strap_d;
			strap_ok_q <= strap_ok_d;
		end
	end
	logic rst_rel;                    // Filtered pin just released
	logic rstf_dly_q;
	always_ff @(posedge clk) begin
		if (rst)
			rstf_dly_q <= 1'b1;
		else
			rstf_dly_q <= rstf_q;
	end
	assign rst_rel = rstf_q & ~rstf_dly_q;

	////////////////////////////////////////////////////////////////////////
	// Configuration, watchdog, cyclic sense and mode machine
	sbc_cfg_t    cfg_q, cfg_d;        // Software settings
	logic [31:0] tmr_q, tmr_d;        // Mode timer
	logic [31:0] wd_q, wd_d;          // Watchdog counter
	logic [31:0] cyc_q, cyc_d;        // Cyclic sense counter
	logic [1:0]  smp_q, smp_d;        // Last cyclic samples
	logic        smp_v_q, smp_v_d;    // Sample history valid
	logic [1:0]  lvl_q, lvl_d;        // Previous wake levels
	logic        drv_q, drv_d;        // Driving reset pin low
	logic        wd_fail;
	logic        cyc_on, lx_wake, cyc_wake;
	logic        use_a, use_b;
	logic        active;
	logic [31:0] wd_per;
	assign active = (mode_q == ST_NREQ) || (mode_q == ST_NORMAL);
	assign use_a  = (cfg_q.mux_sel != MUX_WAKE_A);
	assign use_b  = (cfg_q.mux_sel != MUX_WAKE_B);
	assign rd_a   = wa_s & use_a;
	assign rd_b   = wb_s & use_b;
	assign wd_per = (strap_q == STRAP_RES) ? WDW_CYC : WDD_CYC;
	assign cyc_on = cfg_q.cyc_en && cyc_q < CS_ON_CYC;
	assign lx_wake = !cfg_q.cyc_en && (((wa_s != lvl_q[1]) && use_a) ||
		((wb_s != lvl_q[0]) && use_b));
	assign cyc_wake = cfg_q.cyc_en && smp_v_q && cyc_q == CS_ON_CYC &&
		({rd_a, rd_b} != smp_q);
	always_comb begin
		cfg_d   = cfg_q;
		mode_d  = mode_q;
		tmr_d   = tmr_q + 32'h1;
		wd_d    = wd_q;
		cyc_d   = cyc_q;
		smp_d   = smp_q;
		smp_v_d = smp_v_q;
		lvl_d   = {wa_s, wb_s};
		drv_d   = drv_q;
		wd_fail = 1'b0;
		// Decode accepted frames
		if (frm_q && (active || mode_q == ST_STOP)) begin
			unique case (frame_q.cmd)
				CMD_HS: begin
					cfg_d.hs_on  = frame_q.arg[0];
					cfg_d.hs_pwm = frame_q.arg[1];
				end
				CMD_LS: begin
					cfg_d.ls_a_on = frame_q.arg[0];
					cfg_d.ls_b_on = frame_q.arg[1];
					cfg_d.ls_pwm  = frame_q.arg[2];
				end
				CMD_MUX: begin
					cfg_d.mux_sel = frame_q.arg[1:0];
					cfg_d.div_hi  = frame_q.arg[2];
				end
				CMD_CFG: begin
					cfg_d.cyc_en   = frame_q.arg[0];
					cfg_d.lin_fast = frame_q.arg[1];
				end
				CMD_WDT: begin
					// Early trigger in closed half fails
					if (strap_q == STRAP_RES && wd_q < (wd_per >> 1))
						wd_fail = 1'b1;
					wd_d = 32'h0;
				end
				default: begin
				end
			endcase
		end
		// Watchdog runs in Normal unless strapped off
		if (mode_q == ST_NORMAL && strap_q != STRAP_GND) begin
			wd_d = wd_d + 32'h1;
			if (wd_q >= wd_per)
				wd_fail = 1'b1;
		end else
			wd_d = 32'h0;
		// Cyclic sense timing in low power
		if (cfg_q.cyc_en && (mode_q == ST_STOP || mode_q == ST_SLEEP)) begin
			cyc_d = (cyc_q >= CSP_CYC - 1) ? 32'h0 : cyc_q + 32'h1;
			if (cyc_q == CS_ON_CYC) begin
				smp_d   = {rd_a, rd_b};
				smp_v_d = 1'b1;
			end
		end else begin
			cyc_d   = 32'h0;
			smp_v_d = 1'b0;
		end
		unique case (mode_q)
			ST_RESET: begin
				// Hold pin low for the reset pulse, then release
				if (tmr_q >= RST_CYC - 1)
					drv_d = 1'b0;
				if (!drv_q && rst_rel)
					mode_d = ST_NREQ;
			end
			ST_NREQ: begin
				if (frm_q && frame_q.cmd == CMD_MODE && frame_q.arg[1:0] == REQ_NORMAL)
					mode_d = ST_NORMAL;
				else if (tmr_q >= NREQ_CYC - 1)
					mode_d = ST_RESET;
			end
			ST_NORMAL: begin
				if (frm_q && frame_q.cmd == CMD_MODE && frame_q.arg[1:0] == REQ_STOP)
					mode_d = ST_STOP;
				else if (frm_q && frame_q.cmd == CMD_MODE && frame_q.arg[1:0] == REQ_SLEEP)
					mode_d = ST_SLEEP;
			end
			ST_STOP: begin
				if (cs_rise || lx_wake || cyc_wake)
					mode_d = ST_NREQ;
			end
			ST_SLEEP: begin
				if (lx_wake || cyc_wake)
					mode_d = ST_RESET;
			end
		endcase
		if (wd_fail)
			mode_d = ST_RESET;
		// External reset of the MCU restarts in Normal Request
		if (mode_q != ST_RESET && rst_rel)
			mode_d = ST_NREQ;
		if (mode_d != mode_q) begin
			tmr_d = 32'h0;
			drv_d = (mode_d == ST_RESET);
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			cfg_q   <= CFG_RST;
			mode_q  <= ST_RESET;
			tmr_q   <= 32'h0;
			wd_q    <= 32'h0;
			cyc_q   <= 32'h0;
			smp_q   <= 2'h0;
			smp_v_q <= 1'b0;
			lvl_q   <= 2'h0;
			drv_q   <= 1'b1;
		end else begin
			cfg_q   <= cfg_d;
			mode_q  <= mode_d;
			tmr_q   <= tmr_d;
			wd_q    <= wd_d;
			cyc_q   <= cyc_d;
			smp_q   <= smp_d;
			smp_v_q <= smp_v_d;
			lvl_q   <= lvl_d;
			drv_q   <= drv_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Event flags and interrupt
	logic rst_low;                    // Reset pin seen low
	logic irq_n_q, irq_n_d;
	logic stop_wake;
	assign rst_low   = !rstf_q || drv_q;
	assign stop_wake = (mode_q == ST_STOP) && (lx_wake || cyc_wake);
	always_comb begin
		evt_d = evt_q;
		// Status read clears what it reported
		if (frm_q && frame_q.cmd == CMD_READ)
			evt_d = evt_q & ~snap_q;
		// Setting wins over the clear
		if (active && !rst_low)
			evt_d.fault = evt_d.fault | flt_s;
		if (stop_wake && !rst_low)
			evt_d.wake = 1'b1;
		irq_n_d = !((|evt_d) && !rst_low &&
			(active || mode_q == ST_STOP));
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			evt_q   <= '0;
			irq_n_q <= 1'b1;
		end else begin
			evt_q   <= evt_d;
			irq_n_q <= irq_n_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registered outputs
	logic hs_q, lsa_q, lsb_q, hs_d, lsa_d, lsb_d;
	always_comb begin
		// PWM steers switches only when enabled and active
		hs_d  = active && (cfg_q.hs_pwm ? pwm_s : cfg_q.hs_on);
		lsa_d = active && (cfg_q.ls_pwm ? pwm_s : cfg_q.ls_a_on);
		lsb_d = active && (cfg_q.ls_pwm ? pwm_s : cfg_q.ls_b_on);
		if (cyc_on && (mode_q == ST_STOP || mode_q == ST_SLEEP))
			hs_d = 1'b1;
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			hs_q  <= 1'b0;
			lsa_q <= 1'b0;
			lsb_q <= 1'b0;
		end else begin
			hs_q  <= hs_d;
			lsa_q <= lsa_d;
			lsb_q <= lsb_d;
		end
	end
	assign high_side_switch  = hs_q;
	assign low_side_switch_a = lsa_q;
	assign low_side_switch_b = lsb_q;
	assign analog_mux_output = cfg_q.mux_sel;
	assign divider_hi_ratio  = cfg_q.div_hi;
	assign divider_conn_a    = !use_a;
	assign divider_conn_b    = !use_b;
	assign regulator_on      = (mode_q != ST_SLEEP);
	assign regulator_limited = (mode_q == ST_STOP);
	assign lin_enable        = active;
	assign lin_slew_fast     = cfg_q.lin_fast;
	assign mode_state        = mode_q;
	assign irq_n             = irq_n_q;
	assign rst_pin_n_o       = 1'b0;
	assign rst_pin_n_oe      = drv_q;

	////////////////////////////////////////////////////////////////////////
	// Assertions
	sequence seq_cs_rise;
		!cs_s3_q ##0 cs_s;
	endsequence
	sequence seq_full_frame;
		seq_cs_rise ##0 (bit_q == FRAME_BITS);
	endsequence
	AST_FRAME_LATCH: assert property (@(posedge clk) disable iff (rst)
		seq_full_frame |=> frm_q && frame_q == $past(rx_q))
		else $error("full frame not latched");
	AST_BAD_FRAME: assert property (@(posedge clk) disable iff (rst)
		(seq_cs_rise ##0 (bit_q != FRAME_BITS)) |=> !frm_q && $stable(frame_q))
		else $error("short or long frame accepted");
	AST_STOP_CS_WAKE: assert property (@(posedge clk) disable iff (rst)
		(mode_q == ST_STOP) ##0 seq_cs_rise ##0 !wd_fail |=> mode_q == ST_NREQ)
		else $error("chip select rise did not wake from stop");
	AST_PWM_GATE: assert property (@(posedge clk) disable iff (rst)
		!active && !cyc_on |=> !high_side_switch && !low_side_switch_a && !low_side_switch_b)
		else $error("switch driven outside active modes");
	AST_RST_PULSE: assert property (@(posedge clk) disable iff (rst)
		$rose(mode_q == ST_RESET) |-> rst_pin_n_oe [*8])
		else $error("reset pin not driven low on reset");
	AST_NO_IRQ_RST: assert property (@(posedge clk) disable iff (rst)
		rst_low |=> irq_n)
		else $error("interrupt while reset pin low");
	AST_IRQ_ACK: assert property (@(posedge clk) disable iff (rst)
		$rose(irq_n) && $past(active) && $past(!rst_low) && $past(active, 2) |->
			$past(frm_q) && $past(frame_q.cmd) == CMD_READ)
		else $error("interrupt released without status read");
	AST_MUX_DIV: assert property (@(posedge clk) disable iff (rst)
		divider_conn_a |-> analog_mux_output == MUX_WAKE_A)
		else $error("divider connected while not selected");
	AST_SLEEP_REG: assert property (@(posedge clk) disable iff (rst)
		mode_q == ST_SLEEP |-> !regulator_on && !regulator_limited)
		else $error("regulator on in sleep");
	AST_WD_OVF: assert property (@(posedge clk) disable iff (rst)
		mode_q == ST_NORMAL && strap_q != STRAP_GND && wd_q >= wd_per |=> mode_q == ST_RESET)
		else $error("watchdog overflow did not reset");
	AST_RST_FILT: assert property (@(posedge clk) disable iff (rst)
		$fell(rstf_q) |-> $past(!rstp_s, 2))
		else $error("reset pin glitch passed");
endmodule // sbc_mcu_ctrl
`default_nettype wire

// ==== design/sbc_pkg.sv ====
// Purpose: Shared constants, types and timing for the MCU control block
// Assumes: 200 MHz system clock
// Notes:   Long counts feed top-level parameters so a bench can shorten them
package sbc_pkg;
	// Clock period
	localparam int CLK_NS        = 5;
	// Reset pulse driven on the reset pin
	localparam int RST_PULSE_NS  = 1000000;
	localparam int RST_PULSE_CYC = (RST_PULSE_NS + CLK_NS - 1) / CLK_NS;
	// Normal request timeout
	localparam int NREQ_TMO_NS   = 150000000;
	localparam int NREQ_TMO_CYC  = NREQ_TMO_NS / CLK_NS;
	// Watchdog default period (strap open)
	localparam int WD_DEF_NS     = 150000000;
	localparam int WD_DEF_CYC    = WD_DEF_NS / CLK_NS;
	// Watchdog window period (strap through resistor)
	localparam int WD_WIN_NS     = 20000000;
	localparam int WD_WIN_CYC    = WD_WIN_NS / CLK_NS;
	// Cyclic sense period and on time
	localparam int CS_PERIOD_NS  = 50000000;
	localparam int CS_PERIOD_CYC = CS_PERIOD_NS / CLK_NS;
	localparam int CS_ON_NS      = 10000;
	localparam int CS_ON_CYC     = (CS_ON_NS + CLK_NS - 1) / CLK_NS;
	// Reset pin glitch filter, least stable time
	localparam int RST_FILT_NS   = 1000;
	localparam logic [7:0] RST_FILT_CYC = 8'((RST_FILT_NS + CLK_NS - 1) / CLK_NS);
	// Serial frame length
	localparam logic [3:0] FRAME_BITS = 4'h8;
	// Frame commands
	localparam logic [2:0] CMD_READ = 3'h0;
	localparam logic [2:0] CMD_MODE = 3'h1;
	localparam logic [2:0] CMD_HS   = 3'h2;
	localparam logic [2:0] CMD_LS   = 3'h3;
	localparam logic [2:0] CMD_MUX  = 3'h4;
	localparam logic [2:0] CMD_CFG  = 3'h5;
	localparam logic [2:0] CMD_WDT  = 3'h6;
	// Mode request codes
	localparam logic [1:0] REQ_NORMAL = 2'h0;
	localparam logic [1:0] REQ_STOP   = 2'h1;
	localparam logic [1:0] REQ_SLEEP  = 2'h2;
	// Analog multiplexer sources
	localparam logic [1:0] MUX_BATT   = 2'h0;
	localparam logic [1:0] MUX_WAKE_A = 2'h1;
	localparam logic [1:0] MUX_WAKE_B = 2'h2;
	localparam logic [1:0] MUX_TEMP   = 2'h3;
	// Watchdog strap decode
	localparam logic [1:0] STRAP_GND  = 2'h0;
	localparam logic [1:0] STRAP_OPEN = 2'h1;
	localparam logic [1:0] STRAP_RES  = 2'h2;
	// Operating states
	typedef enum logic [4:0] {
		ST_RESET  = 5'h01,
		ST_NREQ   = 5'h02,
		ST_NORMAL = 5'h04,
		ST_STOP   = 5'h08,
		ST_SLEEP  = 5'h10
	} sbc_mode_t;
	// One received frame
	typedef struct packed {
		logic [2:0] cmd;
		logic [4:0] arg;
	} sbc_frame_t;
	// Sticky event flags
	typedef struct packed {
		logic [3:0] fault;
		logic       wake;
	} sbc_evt_t;
	// Software configuration
	typedef struct packed {
		logic       hs_on;
		logic       hs_pwm;
		logic       ls_a_on;
		logic       ls_b_on;
		logic       ls_pwm;
		logic [1:0] mux_sel;
		logic       div_hi;
		logic       cyc_en;
		logic       lin_fast;
	} sbc_cfg_t;
	localparam sbc_cfg_t CFG_RST = '0;
endpackage

// ==== tb/sbc_spi_master.sv ====
// Purpose: Serial master model driving the control block link
// Assumes: 80 ns half period of sclk, 5 ns system clock
// Notes:   Link clock idles low between frames
`timescale 1ns/1ps
`default_nettype none
module sbc_spi_master (
	input  wire logic clk,
	output logic      sclk,
	output logic      cs_n,
	output logic      mosi,
	input  wire logic miso
);
	////////////////////////////////////////////////////////////////////////
	// Idle levels at time zero
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
	end
	// Wait n cycles, then step off the edge
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// One frame of nb bits, MSB first
	task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
		rx = 8'h00;
		cs_n = 1'b0;
		wt(16);
		for (int i = 0; i < nb; i++) begin
			mosi = tx[7-i];
			wt(16);
			rx = {rx[6:0], miso};
			sclk = 1'b1;
			wt(16);
			sclk = 1'b0;
		end
		wt(16);
		cs_n = 1'b1;
		mosi = ~mosi; // Released data line shows no stale value
		wt(16);
	endtask
endmodule // sbc_spi_master
`default_nettype wire

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench of the MCU control block
// Assumes: Shortened counts through top parameters
// Notes:   Random stimulus from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import sbc_pkg::*;
	logic clk, rst, sclk, cs_n, mosi, miso_o, miso_oe, rst_pin_n_o, rst_pin_n_oe, irq_n;
	logic ext_rst, pwm, wa, wb, hs, lsa, lsb, div_hi, dca, dcb, reg_on, reg_lim, lin_en, lin_fast;
	logic [1:0] strap, mux, s;
	logic [3:0] fault;
	logic [4:0] mode;
	logic [7:0] rx;
	int         n_fail, n_checks, b;
	// Reset pin: pull-up, device and bench pull-downs
	wire rpin = ~((rst_pin_n_oe & ~rst_pin_n_o) | ext_rst);
	wire miso = miso_oe ? miso_o : ~miso_o;
	////////////////////////////////////////////////////////////////////////
	sbc_mcu_ctrl #(.RST_CYC(400), .NREQ_CYC(20000), .WDD_CYC(1000), .WDW_CYC(1000), .CSP_CYC(3000)) DUT (
		.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso_o(miso_o), .miso_oe(miso_oe),
		.rst_pin_n_i(rpin), .rst_pin_n_o(rst_pin_n_o), .rst_pin_n_oe(rst_pin_n_oe), .irq_n(irq_n),
		.watchdog_strap_pin(strap), .pwm_drive_input(pwm), .wake_input_a(wa), .wake_input_b(wb),
		.fault_i(fault), .high_side_switch(hs), .low_side_switch_a(lsa), .low_side_switch_b(lsb),
		.analog_mux_output(mux), .divider_hi_ratio(div_hi), .divider_conn_a(dca), .divider_conn_b(dcb),
		.regulator_on(reg_on), .regulator_limited(reg_lim), .lin_enable(lin_en),
		.lin_slew_fast(lin_fast), .mode_state(mode));
	sbc_spi_master u_m (.clk(clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
	////////////////////////////////////////////////////////////////////////
	// Clock and watchdog
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		repeat (60000) @(posedge clk);
		n_fail++;
		summarize();
	end
	// Divider connections expected for a mux source
	function automatic logic [7:0] conn(input logic [1:0] sel);
		return {6'h00, sel == MUX_WAKE_A, sel == MUX_WAKE_B};
	endfunction
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			$display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
			n_fail++;
		end
	endtask
	task automatic send(input logic [7:0] f);
		u_m.xfer(f, 8, rx);
		wt(4);
	endtask
	task automatic wait_mode(input logic [4:0] m);
		for (int i = 0; i < 3000 && mode !== m; i++) wt(1);
		chk(8'(mode), 8'(m));
	endtask
	task automatic summarize();
		if (n_fail == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		void'($urandom(32'ha5e554cb));
		{rst, ext_rst, pwm, wa, wb, fault, strap, n_fail, n_checks} = {5'h10, 4'h0, STRAP_GND, 64'h0};
		wt(8);
		rst = 1'b0;
		chk({mode, rst_pin_n_oe, irq_n, 1'b0}, {ST_RESET, 3'h6});
		wait_mode(ST_NREQ);
		chk({miso_oe, irq_n}, 8'h01);
		send({CMD_MODE, 3'h0, REQ_NORMAL});
		chk(8'(mode), 8'(ST_NORMAL));
		send({CMD_HS, 5'h01});
		send({CMD_LS, 5'h03});
		send({CMD_CFG, 5'h02});
		chk({hs, lsa, lsb, lin_en, lin_fast}, 8'h1f);
		u_m.xfer({CMD_HS, 5'h00}, 7, rx);
		wt(20);
		chk(8'(hs), 8'h01);
		// Every mux source, then random ones, ending on wake A
		for (int i = 0; i < 7; i++) begin
			s = (i < 4) ? 2'(i) : (i == 6) ? MUX_WAKE_A : 2'($urandom);
			send({CMD_MUX, 2'h0, 1'(i), s});
			chk({mux, div_hi}, {5'h00, s, 1'(i)});
			chk({dca, dcb}, conn(s));
		end
		send({CMD_HS, 5'h02});
		send({CMD_LS, 5'h07});
		for (int i = 0; i < 8; i++) begin
			pwm = (i < 2) ? 1'(i) : 1'($urandom);
			wt(8);
			chk({hs, lsa, lsb}, {3{pwm}});
		end
		b = $urandom % 4;
		fault[b] = 1'b1;
		wt(4);
		chk(8'(irq_n), 8'h00);
		fault = 4'h0;
		wt(4);
		chk(8'(irq_n), 8'h00);
		send({CMD_READ, 5'h00});
		chk({rx[7:4], irq_n}, {3'h0, 4'(1 << b), 1'b1});
		send({CMD_MODE, 3'h0, REQ_STOP});
		chk({mode, reg_lim}, {2'h0, ST_STOP, 1'b1});
		send({CMD_READ, 5'h00});
		chk({mode, irq_n}, {2'h0, ST_NREQ, 1'b1});
		send({CMD_MODE, 3'h0, REQ_NORMAL});
		send({CMD_MODE, 3'h0, REQ_STOP});
		wa = ~wa;
		wt(20);
		chk(8'(mode), 8'(ST_STOP));
		wb = ~wb;
		wt(20);
		chk({mode, irq_n}, {2'h0, ST_NREQ, 1'b0});
		send({CMD_READ, 5'h00});
		chk(8'(rx[3:1]), {5'h00, 1'b1, 1'b0, wb});
		send({CMD_MODE, 3'h0, REQ_NORMAL});
		send({CMD_MUX, 5'h00});
		// Cyclic sense in Stop: switch pulses, a changed sample wakes
		send({CMD_CFG, 5'h03});
		send({CMD_MODE, 3'h0, REQ_STOP});
		wt(20);
		chk(8'(hs), 8'h01);
		wt(2500);
		chk(8'(hs), 8'h00);
		wa = ~wa;
		wait_mode(ST_NREQ);
		chk(8'(irq_n), 8'h00);
		send({CMD_READ, 5'h00});
		chk({rx[3], irq_n}, 8'h03);
		send({CMD_MODE, 3'h0, REQ_NORMAL});
		send({CMD_CFG, 5'h02});
		// Reset pin glitch, then a long external reset, a fault raised while it is low
		ext_rst = 1'b1;
		wt(20);
		ext_rst = 1'b0;
		wt(20);
		chk(8'(mode), 8'(ST_NORMAL));
		ext_rst = 1'b1;
		wt(250);
		fault[0] = 1'b1;
		wt(150);
		chk(8'(irq_n), 8'h01);
		fault = 4'h0;
		ext_rst = 1'b0;
		wait_mode(ST_NREQ);
		chk(8'(irq_n), 8'h01);
		send({CMD_MODE, 3'h0, REQ_NORMAL});
		send({CMD_MODE, 3'h0, REQ_SLEEP});
		chk({mode, reg_on}, {2'h0, ST_SLEEP, 1'b0});
		wa = ~wa;
		wt(20);
		chk({mode, rst_pin_n_oe}, {2'h0, ST_RESET, 1'b1});
		wait_mode(ST_NREQ);
		// Open strap: default watchdog must overflow without triggers
		strap = STRAP_OPEN;
		rst = 1'b1;
		wt(8);
		rst = 1'b0;
		wait_mode(ST_NREQ);
		send({CMD_MODE, 3'h0, REQ_NORMAL});
		for (int i = 0; i < 1500 && rst_pin_n_oe !== 1'b1; i++) wt(1);
		chk(8'(rst_pin_n_oe), 8'h01);
		// Window strap: a trigger in the open half holds Normal, an early one resets
		strap = STRAP_RES;
		rst = 1'b1;
		wt(8);
		rst = 1'b0;
		wait_mode(ST_NREQ);
		send({CMD_MODE, 3'h0, REQ_NORMAL});
		wt(300);
		send({CMD_WDT, 5'h00});
		chk(8'(mode), 8'(ST_NORMAL));
		send({CMD_WDT, 5'h00});
		chk({mode, rst_pin_n_oe}, {2'h0, ST_RESET, 1'b1});
		summarize();
	end
endmodule // testbench
`default_nettype wire
